// ==== core/ctss_map.svh ====
// Register indices, field positions, reset values and constants of the time scale synchronizer
// How it works
// [R1] Selected source time stamp is one event
// [R2] Host writes event time before next event
// [R3] Common time is shifted copy of local
// [R4] Loop reference switch selects matching sync source
// [R5] Five-bit selectors in primary and secondary registers
// [R6] Legacy loop mode uses primary selector only
// [R7] Codes 0x1E/0x1F trigger from local time
// [R8] Switchover swaps time target and skew set
// [R9] Switchover discards all captured sync data
// [R10] Switchover keeps applied offset untouched
// [R11] Time update without capture flags error
// [R12] First event errors; next event synchronizes
// [R13] Tagged mode never applies to immediate trigger
// [R14] Selector bit 7 keeps only tagged stamps
// [R15] Host writes 96-bit time in twelve bytes
// [R16] Target 0x30 primary, 0x31 secondary
// [R17] Update strobe takes time for previous event
// [R18] Integer seconds are 48 bits either format
// [R19] Fractional format: 48 bits of 2^-48 s
// [R20] PTP format: 46 bits of 2^-16 ns
// [R21] Per-path 24-bit signed skew added to time
// [R22] Skew is two's complement, 2^-48 s
// [R23] Offset is time plus skew minus capture
`ifndef CTSS_MAP_SVH
`define CTSS_MAP_SVH

// ----------------------------------------
// Register indices, byte address is four times the index
// ----------------------------------------
`define CTSS_IDX_STROBE 14'h000F
`define CTSS_IDX_PRIM_SEL 14'h0D11
`define CTSS_IDX_PRIM_SKEW 14'h0D1B
`define CTSS_IDX_SEC_SEL 14'h0D21
`define CTSS_IDX_SEC_SKEW 14'h0D2B
`define CTSS_IDX_CTRL 14'h0D3E
`define CTSS_IDX_STATUS 14'h0D3F
`define CTSS_IDX_TARGET 14'h0F09
`define CTSS_IDX_TIME 14'h0F0A

// ----------------------------------------
// Field layout and codes
// ----------------------------------------
`define CTSS_TIME_BYTES 12
`define CTSS_SKEW_BYTES 3
`define CTSS_SEL_CODE_W 5
`define CTSS_SEL_TAG_BIT 7
`define CTSS_SEL_IMM_PRIM 5'h1E
`define CTSS_SEL_IMM_SEC 5'h1F
`define CTSS_TARGET_PRIM 5'h10
`define CTSS_TARGET_SEC 5'h11
`define CTSS_STROBE_BIT 0
`define CTSS_CTRL_PTP_BIT 0
`define CTSS_SEC_W 48
`define CTSS_PTP_FRAC_W 46
// 2^64 / 1e9 rounded; ns*2^16 units times this, shifted by 32, gives 2^-48 s units
`define CTSS_PTP_SCALE 35'h4_4B82_FA0A
`define CTSS_PTP_SHIFT 32

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CTSS_RST_BYTE 8'h00
`define CTSS_RST_TIME 96'h0

`endif

// ==== core/ctss_pkg.sv ====
// Types shared by the time scale synchronizer
package ctss_pkg;
    // Pairing state of captured event and programmed time
    typedef enum logic [2:0] {
        CTSS_EMPTY = 3'b001,
        CTSS_CAPTURED = 3'b010,
        CTSS_STAGED = 3'b100
    } ctss_state_type;
endpackage

// ==== core/ctss_top.sv ====
// Common time scale synchronizer with APB register slave
`include "ctss_map.svh"

module ctss_top #(
    parameter int ADDR_W = 16
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ref_secondary,
    input wire logic legacy_aux_mode,
    input wire logic stamp_valid,
    input wire logic [4:0] stamp_source,
    input wire logic stamp_tagged,
    input wire logic [95:0] stamp_time,
    input wire logic [95:0] local_time,
    output logic [95:0] common_time,
    output logic sync_error,
    output logic synced,
    output logic active_secondary
);

    // ----------------------------------------
    // Elaboration checks
    // ----------------------------------------
    // Word index is paddr[15:2], 14 bits above the two byte bits
    generate
        if (ADDR_W < 16) begin : g_bad_addr
            $error("ctss_top: ADDR_W must be at least 16");
        end
    endgenerate

    // ----------------------------------------
    // Decode functions
    // ----------------------------------------
    // Immediate trigger codes share one test
    function automatic logic sel_immediate(input logic [7:0] s);
        return (s[4:0] == `CTSS_SEL_IMM_PRIM) || (s[4:0] == `CTSS_SEL_IMM_SEC);
    endfunction

    // Index lies inside a run of byte registers
    function automatic logic in_run(input logic [13:0] idx, input logic [13:0] base, input int n);
        return (idx >= base) && (idx < base + 14'(n));
    endfunction

    // ----------------------------------------
    // APB decode
    // ----------------------------------------
    logic [13:0] idx; // Word index of the access
    logic setup_ph; // First cycle of a transfer
    logic access_ph; // Completing cycle
    logic wr; // Write takes effect
    logic mapped; // Index hits a register
    assign idx = paddr[15:2];
    assign setup_ph = psel && !penable;
    assign access_ph = psel && penable;
    assign wr = access_ph && pwrite && mapped;
    // Zero wait states: every access finishes in its access phase
    assign pready = 1'b1;
    assign pslverr = access_ph && !mapped;
    assign mapped = (idx == `CTSS_IDX_STROBE) || (idx == `CTSS_IDX_PRIM_SEL) ||
                    (idx == `CTSS_IDX_SEC_SEL) || (idx == `CTSS_IDX_CTRL) ||
                    (idx == `CTSS_IDX_STATUS) || (idx == `CTSS_IDX_TARGET) ||
                    in_run(idx, `CTSS_IDX_PRIM_SKEW, `CTSS_SKEW_BYTES) ||
                    in_run(idx, `CTSS_IDX_SEC_SKEW, `CTSS_SKEW_BYTES) ||
                    in_run(idx, `CTSS_IDX_TIME, `CTSS_TIME_BYTES);

    // ----------------------------------------
    // Software registers
    // ----------------------------------------
    logic [7:0] prim_sel; // Primary source selector, bit 7 tagged only
    logic [7:0] sec_sel; // Secondary source selector
    logic [7:0] target; // Time target code
    logic [7:0] ctrl; // Bit 0 selects PTP time format
    logic [7:0] prim_skew_b [`CTSS_SKEW_BYTES]; // Primary skew bytes, LSB first
    logic [7:0] sec_skew_b [`CTSS_SKEW_BYTES]; // Secondary skew bytes
    logic [7:0] tstage [`CTSS_TIME_BYTES]; // Time bytes, LSB first
    logic strobe; // One-cycle update strobe

    // Single-byte registers
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            prim_sel <= `CTSS_RST_BYTE;
            sec_sel <= `CTSS_RST_BYTE;
            target <= `CTSS_RST_BYTE;
            ctrl <= `CTSS_RST_BYTE;
        end else if (wr) begin
            if (idx == `CTSS_IDX_PRIM_SEL) prim_sel <= pwdata[7:0]; // [R5]
            if (idx == `CTSS_IDX_SEC_SEL) sec_sel <= pwdata[7:0]; // [R5]
            if (idx == `CTSS_IDX_TARGET) target <= pwdata[7:0];
            if (idx == `CTSS_IDX_CTRL) ctrl <= pwdata[7:0];
        end
    end

    // Strobe bit never stores; it only pulses
    assign strobe = wr && (idx == `CTSS_IDX_STROBE) && pwdata[`CTSS_STROBE_BIT]; // [R17]

    // Skew bytes for both paths
    genvar gi;
    generate
        for (gi = 0; gi < `CTSS_SKEW_BYTES; gi++) begin : g_skew
            always_ff @(posedge core_clk or negedge nrst) begin
                if (!nrst) begin
                    prim_skew_b[gi] <= `CTSS_RST_BYTE;
                    sec_skew_b[gi] <= `CTSS_RST_BYTE;
                end else if (wr) begin
                    if (idx == `CTSS_IDX_PRIM_SKEW + 14'(gi)) prim_skew_b[gi] <= pwdata[7:0]; // [R21]
                    if (idx == `CTSS_IDX_SEC_SKEW + 14'(gi)) sec_skew_b[gi] <= pwdata[7:0]; // [R21]
                end
            end
        end
        // Twelve time bytes of the 96-bit value
        for (gi = 0; gi < `CTSS_TIME_BYTES; gi++) begin : g_time
            always_ff @(posedge core_clk or negedge nrst) begin
                if (!nrst) begin
                    tstage[gi] <= `CTSS_RST_BYTE;
                end else if (wr && idx == `CTSS_IDX_TIME + 14'(gi)) begin
                    tstage[gi] <= pwdata[7:0]; // [R15]
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // Assembled words
    // ----------------------------------------
    logic [95:0] time_word; // Programmed time as written
    logic [23:0] prim_skew; // Primary skew word
    logic [23:0] sec_skew; // Secondary skew word
    always_comb begin
        for (int i = 0; i < `CTSS_TIME_BYTES; i++) time_word[i*8 +: 8] = tstage[i];
        for (int i = 0; i < `CTSS_SKEW_BYTES; i++) begin
            prim_skew[i*8 +: 8] = prim_skew_b[i];
            sec_skew[i*8 +: 8] = sec_skew_b[i];
        end
    end

    // ----------------------------------------
    // Reference tracking
    // ----------------------------------------
    logic act_q; // Secondary path in use
    logic next_act;
    logic switch_now; // Loop changed reference this cycle
    // Legacy loop never uses the secondary path
    assign next_act = ref_secondary && !legacy_aux_mode; // [R4] [R6]
    assign switch_now = next_act != act_q; // [R4]
    assign active_secondary = act_q;

    // Reference follower
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) act_q <= 1'b0;
        else act_q <= next_act;
    end

    // ----------------------------------------
    // Event detection
    // ----------------------------------------
    logic [7:0] act_sel; // Selector of the active path
    logic imm; // Immediate trigger selected
    logic [47:0] secs_q; // Last local seconds
    logic imm_tick; // Local seconds advanced
    logic ext_event; // Accepted external stamp
    logic sync_event; // One synchronization event
    logic [95:0] event_stamp; // Time captured at the event
    assign act_sel = act_q ? sec_sel : prim_sel; // [R4]
    assign imm = sel_immediate(act_sel); // [R7]
    assign imm_tick = local_time[95:48] != secs_q; // [R7]
    // Tag filter is skipped for immediate trigger since imm gates it out
    assign ext_event = stamp_valid && !imm && (stamp_source == act_sel[4:0]) &&
                       (!act_sel[`CTSS_SEL_TAG_BIT] || stamp_tagged); // [R1] [R13] [R14]
    assign sync_event = imm ? imm_tick : ext_event; // [R1] [R7]
    assign event_stamp = imm ? local_time : stamp_time; // [R7]

    // Seconds watcher for immediate trigger
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) secs_q <= 48'h0;
        else secs_q <= local_time[95:48];
    end

    // ----------------------------------------
    // Time conversion and offset
    // ----------------------------------------
    logic [80:0] ptp_prod; // PTP fraction times scale
    logic [47:0] ptp_frac; // PTP fraction in 2^-48 s
    logic [95:0] prog_time; // Programmed time in seconds format
    logic [95:0] skew_ext; // Active skew, sign-extended
    logic [95:0] captured; // Time at the last event
    logic [95:0] new_off; // Offset for the captured event
    logic upd_match; // Strobe aimed at the active path
    logic [4:0] want_target; // Target code of active path
    assign ptp_prod = 81'(time_word[`CTSS_PTP_FRAC_W-1:0]) * 81'(`CTSS_PTP_SCALE); // [R20]
    assign ptp_frac = ptp_prod[`CTSS_PTP_SHIFT +: 48]; // [R20]
    // Seconds field is common to both formats
    assign prog_time = ctrl[`CTSS_CTRL_PTP_BIT] ? {time_word[95:48], ptp_frac} : time_word; // [R18] [R19]
    assign skew_ext = 96'(signed'(act_q ? sec_skew : prim_skew)); // [R8] [R21] [R22]
    assign new_off = prog_time + skew_ext - captured; // [R23]
    assign want_target = act_q ? `CTSS_TARGET_SEC : `CTSS_TARGET_PRIM;
    // Only the time bound to the active path is paired
    assign upd_match = strobe && (target[4:0] == want_target); // [R8] [R16] [R17]

    // ----------------------------------------
    // Pairing state machine
    // ----------------------------------------
    ctss_pkg::ctss_state_type state;
    ctss_pkg::ctss_state_type next_state;
    logic [95:0] staged_off; // Offset waiting for next event
    logic [95:0] applied_off; // Offset in effect
    logic [95:0] next_captured;
    logic [95:0] next_staged_off;
    logic [95:0] next_applied_off;
    logic next_sync_error;
    logic next_synced;

    // Switchover beats event beats update; a strobe in an event cycle is dropped
    always_comb begin
        next_state = state;
        next_captured = captured;
        next_staged_off = staged_off;
        next_applied_off = applied_off;
        next_sync_error = sync_error;
        next_synced = synced;
        if (switch_now) begin
            // Flush, but applied offset stays in force
            next_state = ctss_pkg::CTSS_EMPTY; // [R9] [R10]
        end else if (sync_event) begin
            next_captured = event_stamp;
            next_state = ctss_pkg::CTSS_CAPTURED;
            case (state)
                ctss_pkg::CTSS_STAGED: begin
                    next_applied_off = staged_off; // [R12] [R11]
                    next_sync_error = 1'b0;
                    next_synced = 1'b1;
                end
                default: begin
                    next_sync_error = 1'b1; // [R12]
                end
            endcase
        end else if (upd_match) begin
            case (state)
                ctss_pkg::CTSS_CAPTURED: begin
                    next_staged_off = new_off; // [R17] [R23]
                    next_state = ctss_pkg::CTSS_STAGED;
                end
                default: begin
                    next_sync_error = 1'b1; // [R11]
                end
            endcase
        end
    end

    // State and offsets
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state <= ctss_pkg::CTSS_EMPTY;
            captured <= `CTSS_RST_TIME;
            staged_off <= `CTSS_RST_TIME;
            applied_off <= `CTSS_RST_TIME;
            sync_error <= 1'b0;
            synced <= 1'b0;
        end else begin
            state <= next_state;
            captured <= next_captured;
            staged_off <= next_staged_off;
            applied_off <= next_applied_off;
            sync_error <= next_sync_error;
            synced <= next_synced;
        end
    end

    // Common time output, one cycle behind local time
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) common_time <= `CTSS_RST_TIME;
        else common_time <= local_time + applied_off; // [R3]
    end

    // ----------------------------------------
    // Read path
    // ----------------------------------------
    logic [7:0] status; // Live state for software
    logic [7:0] rd_byte; // Selected register byte
    assign status = {3'b000, state == ctss_pkg::CTSS_STAGED, state == ctss_pkg::CTSS_CAPTURED,
                     synced, sync_error, act_q};
    always_comb begin
        rd_byte = 8'h00;
        if (idx == `CTSS_IDX_PRIM_SEL) rd_byte = prim_sel;
        else if (idx == `CTSS_IDX_SEC_SEL) rd_byte = sec_sel;
        else if (idx == `CTSS_IDX_TARGET) rd_byte = target;
        else if (idx == `CTSS_IDX_CTRL) rd_byte = ctrl;
        else if (idx == `CTSS_IDX_STATUS) rd_byte = status;
        else if (in_run(idx, `CTSS_IDX_PRIM_SKEW, `CTSS_SKEW_BYTES))
            rd_byte = prim_skew_b[2'(idx - `CTSS_IDX_PRIM_SKEW)];
        else if (in_run(idx, `CTSS_IDX_SEC_SKEW, `CTSS_SKEW_BYTES))
            rd_byte = sec_skew_b[2'(idx - `CTSS_IDX_SEC_SKEW)];
        else if (in_run(idx, `CTSS_IDX_TIME, `CTSS_TIME_BYTES))
            rd_byte = tstage[4'(idx - `CTSS_IDX_TIME)];
    end

    // Read data latched in setup so it stands through the access phase
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) prdata <= 32'h0000_0000;
        else if (setup_ph) prdata <= {24'h00_0000, rd_byte};
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    flush_on_switch_a: assert property (@(posedge core_clk) disable iff (!nrst) // [R9]
        switch_now |=> state == ctss_pkg::CTSS_EMPTY)
        else $error("capture not flushed on switchover");

    offset_kept_a: assert property (@(posedge core_clk) disable iff (!nrst) // [R10]
        switch_now |=> applied_off == $past(applied_off) && synced == $past(synced))
        else $error("applied offset changed on switchover");

    update_no_event_a: assert property (@(posedge core_clk) disable iff (!nrst) // [R11]
        (upd_match && !switch_now && !sync_event && state != ctss_pkg::CTSS_CAPTURED) |=> sync_error)
        else $error("update without capture did not flag error");

    event_apply_a: assert property (@(posedge core_clk) disable iff (!nrst) // [R12]
        (sync_event && !switch_now && state == ctss_pkg::CTSS_STAGED)
        |=> (applied_off == $past(staged_off)) && !sync_error ##1 common_time == $past(local_time) + applied_off)
        else $error("staged offset not applied at event");

    first_event_err_a: assert property (@(posedge core_clk) disable iff (!nrst) // [R12]
        (sync_event && !switch_now && state == ctss_pkg::CTSS_EMPTY) |=> sync_error && !$changed(applied_off))
        else $error("unpaired event did not flag error");

    tag_filter_a: assert property (@(posedge core_clk) disable iff (!nrst) // [R14]
        (stamp_valid && !imm && act_sel[`CTSS_SEL_TAG_BIT] && !stamp_tagged && !switch_now)
        |=> $stable(captured))
        else $error("untagged stamp captured in tagged mode");

    imm_trigger_a: assert property (@(posedge core_clk) disable iff (!nrst) // [R7]
        (imm && imm_tick && !switch_now) |=> state == ctss_pkg::CTSS_CAPTURED && captured == $past(local_time))
        else $error("immediate trigger did not capture local time");

    time_pair_a: assert property (@(posedge core_clk) disable iff (!nrst) // [R17]
        (upd_match && !switch_now && !sync_event && state == ctss_pkg::CTSS_CAPTURED)
        |=> state == ctss_pkg::CTSS_STAGED && staged_off == $past(prog_time) + $past(skew_ext) - captured)
        else $error("time update not paired with captured event");

    legacy_primary_a: assert property (@(posedge core_clk) disable iff (!nrst) // [R6]
        legacy_aux_mode |=> !act_q)
        else $error("legacy mode selected secondary path");

endmodule

// ==== verification/ctss_stamp_src.sv ====
// Model of the time stamp source and local time scale seen by the synchronizer
module ctss_stamp_src #(
    parameter logic [95:0] STEP = 96'h4000_0000_0000
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic fire,
    input wire logic [4:0] fire_source,
    input wire logic fire_tagged,
    output logic [95:0] local_time,
    output logic stamp_valid,
    output logic [4:0] stamp_source,
    output logic stamp_tagged,
    output logic [95:0] stamp_time
);
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------
    // Local time and stamp generation
    // ----------------------------------------
    // Stamp fields invert when idle so stale values are never mistaken for data
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            local_time <= 96'h0;
            stamp_valid <= 1'b0;
            stamp_source <= 5'h00;
            stamp_tagged <= 1'b0;
            stamp_time <= 96'h0;
        end else begin
            local_time <= local_time + STEP; // Seconds roll every four cycles
            stamp_valid <= fire; // One-cycle pulse per stamp
            stamp_source <= fire ? fire_source : ~stamp_source;
            stamp_tagged <= fire ? fire_tagged : ~stamp_tagged;
            stamp_time <= fire ? local_time : ~stamp_time;
        end
    end
endmodule

// ==== verification/ctss_top_tb.sv ====
// Self-checking bench of the time scale synchronizer
`include "ctss_map.svh"
module ctss_top_tb;
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------
    // Signals and bookkeeping
    // ----------------------------------------
    localparam logic [95:0] STEP = 96'h4000_0000_0000; // Local time advance per cycle
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic ref_secondary = 1'b0;
    logic legacy_aux_mode = 1'b0;
    logic fire = 1'b0;
    logic [4:0] fire_source = 5'h00;
    logic fire_tagged = 1'b0;
    logic stamp_valid;
    logic [4:0] stamp_source;
    logic stamp_tagged;
    logic [95:0] stamp_time;
    logic [95:0] local_time;
    logic [95:0] common_time;
    logic sync_error;
    logic synced;
    logic active_secondary;
    logic [31:0] rd; // Last read data
    logic err; // Last slave error
    logic ptp_mode = 1'b0; // Bench copy of the format bit
    logic [95:0] last_cap = 96'h0; // Stamp time of the latest stamp pulse
    logic [95:0] applied_off = 96'h0; // Offset expected on the common time
    int error_cnt = 0;
    int samples_checked = 0;
    int cyc = 0;

    ctss_top ctss_top_i (.core_clk(core_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ref_secondary(ref_secondary), .legacy_aux_mode(legacy_aux_mode), .stamp_valid(stamp_valid),
        .stamp_source(stamp_source), .stamp_tagged(stamp_tagged), .stamp_time(stamp_time),
        .local_time(local_time), .common_time(common_time), .sync_error(sync_error), .synced(synced),
        .active_secondary(active_secondary));
    ctss_stamp_src #(.STEP(STEP)) ctss_stamp_src_i (.core_clk(core_clk), .nrst(nrst), .fire(fire),
        .fire_source(fire_source), .fire_tagged(fire_tagged), .local_time(local_time),
        .stamp_valid(stamp_valid), .stamp_source(stamp_source), .stamp_tagged(stamp_tagged),
        .stamp_time(stamp_time));

    // ----------------------------------------
    // Clock, capture record and hang guard
    // ----------------------------------------
    initial begin
        forever #2 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        if (stamp_valid === 1'b1) last_cap <= stamp_time;
        cyc++;
        if (cyc == 20000) begin // Far beyond the few hundred cycles needed
            error_cnt++;
            stop_test();
        end
    end

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input logic [95:0] got, input logic [95:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic stop_test;
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic do_reset;
        @(posedge core_clk);
        nrst <= 1'b0;
        ref_secondary <= 1'b0;
        legacy_aux_mode <= 1'b0;
        repeat (3) @(posedge core_clk);
        nrst <= 1'b1;
    endtask
    // One APB transfer; waits on pready, only the hang guard ends a wait
    task automatic apb(input logic wr, input logic [13:0] idx, input logic [7:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h000000, d};
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic fire_stamp(input logic [4:0] s, input logic tg);
        @(posedge core_clk);
        fire <= 1'b1;
        fire_source <= s;
        fire_tagged <= tg;
        @(posedge core_clk);
        fire <= 1'b0;
        repeat (3) @(posedge core_clk);
    endtask
    // Event, time write for it, then the event that applies the offset
    task automatic do_sync(input logic sec, input logic [95:0] t, input logic [23:0] skew);
        logic [95:0] cap;
        logic [80:0] prod;
        fire_stamp(sec ? 5'h05 : 5'h03, 1'b0);
        chk(sync_error, 96'h1);
        cap = last_cap;
        for (int i = 0; i < 12; i++) apb(1'b1, `CTSS_IDX_TIME + 14'(i), t[8*i+:8]);
        apb(1'b1, `CTSS_IDX_TARGET, sec ? 8'h31 : 8'h30);
        apb(1'b1, `CTSS_IDX_STROBE, 8'h01);
        prod = 81'(t[45:0]) * 81'(`CTSS_PTP_SCALE);
        applied_off = (ptp_mode ? {t[95:48], prod[79:32]} : t) + {{72{skew[23]}}, skew} - cap;
        fire_stamp(sec ? 5'h05 : 5'h03, 1'b0);
        chk(sync_error, 96'h0);
        chk(synced, 96'h1);
        @(negedge core_clk);
        chk(common_time, local_time - STEP + applied_off);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_regs;
        apb(1'b0, `CTSS_IDX_STATUS, 8'h00);
        chk(rd, 96'h0);
        apb(1'b1, `CTSS_IDX_PRIM_SEL, 8'h83);
        apb(1'b0, `CTSS_IDX_PRIM_SEL, 8'h00);
        chk(rd, 96'h83);
        apb(1'b1, 14'h0123, 8'h5A);
        chk(err, 96'h1);
        apb(1'b0, 14'h0123, 8'h00);
        chk(rd, 96'h0);
    endtask
    task automatic t_sync;
        apb(1'b1, `CTSS_IDX_PRIM_SEL, 8'h03);
        apb(1'b1, `CTSS_IDX_PRIM_SKEW, 8'h71);
        apb(1'b1, `CTSS_IDX_PRIM_SKEW + 14'h1, 8'h86);
        apb(1'b1, `CTSS_IDX_PRIM_SKEW + 14'h2, 8'hEA);
        do_sync(1'b0, 96'h0000_0002_4328_0DCF_92CF_D0E3, 24'hEA8671);
        apb(1'b1, `CTSS_IDX_CTRL, 8'h01);
        ptp_mode = 1'b1;
        do_sync(1'b0, 96'h0000_0002_4328_0337_309A_0000, 24'hEA8671);
        apb(1'b1, `CTSS_IDX_CTRL, 8'h00);
        ptp_mode = 1'b0;
    endtask
    task automatic t_switch;
        apb(1'b1, `CTSS_IDX_SEC_SEL, 8'h05);
        apb(1'b1, `CTSS_IDX_SEC_SKEW + 14'h1, 8'h01);
        @(posedge core_clk);
        ref_secondary <= 1'b1;
        repeat (3) @(posedge core_clk);
        chk(active_secondary, 96'h1);
        @(negedge core_clk);
        chk(common_time, local_time - STEP + applied_off);
        apb(1'b1, `CTSS_IDX_TARGET, 8'h31);
        apb(1'b1, `CTSS_IDX_STROBE, 8'h01);
        repeat (2) @(posedge core_clk);
        chk(sync_error, 96'h1);
        apb(1'b0, `CTSS_IDX_STATUS, 8'h00);
        chk(rd, 96'h7);
        apb(1'b0, `CTSS_IDX_SEC_SKEW + 14'h1, 8'h00);
        chk(rd, 96'h1);
        do_sync(1'b1, 96'h0000_0002_4329_8000_0000_0000, 24'h000100);
        @(posedge core_clk);
        legacy_aux_mode <= 1'b1;
        repeat (3) @(posedge core_clk);
        chk(active_secondary, 96'h0);
    endtask
    task automatic t_tagged;
        do_reset();
        apb(1'b1, `CTSS_IDX_PRIM_SEL, 8'h83);
        fire_stamp(5'h03, 1'b0);
        chk(sync_error, 96'h0);
        fire_stamp(5'h04, 1'b1);
        chk(sync_error, 96'h0);
        fire_stamp(5'h03, 1'b1);
        chk(sync_error, 96'h1);
    endtask
    task automatic t_immediate;
        do_reset();
        apb(1'b1, `CTSS_IDX_PRIM_SEL, 8'h9E);
        repeat (10) @(posedge core_clk);
        chk(sync_error, 96'h1);
        do_reset();
        apb(1'b1, `CTSS_IDX_SEC_SEL, 8'h1F);
        ref_secondary <= 1'b1;
        repeat (10) @(posedge core_clk);
        chk(sync_error, 96'h1);
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        do_reset();
        t_regs();
        t_sync();
        t_switch();
        t_tagged();
        t_immediate();
        stop_test();
    end
endmodule
